// File: pkg/lpc_pkg.sv
// Shared constants for the low-power SDRAM host controller
package lpc_pkg;

    // System clock and generated memory clock
    localparam int          CLK_NS     = 25;
    localparam int          CK_DIV     = 4;
    localparam logic [1:0]  PH_DEC     = 2'h2;
    localparam logic [1:0]  PH_FALL    = 2'h0;
    localparam logic [1:0]  PH_LAST    = 2'h3;

    // User command codes
    localparam logic [3:0]  CMD_ACT    = 4'h1;
    localparam logic [3:0]  CMD_RD     = 4'h2;
    localparam logic [3:0]  CMD_WR     = 4'h3;
    localparam logic [3:0]  CMD_PRE    = 4'h4;
    localparam logic [3:0]  CMD_PREA   = 4'h5;
    localparam logic [3:0]  CMD_REFAB  = 4'h6;
    localparam logic [3:0]  CMD_REFPB  = 4'h7;
    localparam logic [3:0]  CMD_MRW    = 4'h8;
    localparam logic [3:0]  CMD_MRR    = 4'h9;

    // Opcode bits on the rising half of the command bus
    localparam logic [1:0]  OPC_ACT    = 2'h2;
    localparam logic [2:0]  OPC_RD     = 3'h5;
    localparam logic [2:0]  OPC_WR     = 3'h1;
    localparam logic [3:0]  OPC_PRE    = 4'hB;
    localparam logic [2:0]  OPC_REF    = 3'h4;
    localparam logic [3:0]  OPC_MRW    = 4'h0;
    localparam logic [3:0]  OPC_MRR    = 4'h8;

    // Device timing in ns and in memory clocks
    localparam int T_RCD_NS   = 18;
    localparam int T_RAS_NS   = 42;
    localparam int T_RPPB_NS  = 18;
    localparam int T_RPAB_NS  = 21;
    localparam int T_RC_NS    = T_RAS_NS + T_RPAB_NS;
    localparam int T_RRD_NS   = 10;
    localparam int T_FAW_NS   = 50;
    localparam int T_RFCAB_NS = 210;
    localparam int T_RFCPB_NS = 90;
    localparam int T_XP_NS    = 8;
    localparam int T_WR_NS    = 15;
    localparam int T_MRR_CK   = 4;
    localparam int T_MRW_CK   = 10;
    localparam int RL_CK      = 6;
    localparam int WL_CK      = 3;
    localparam int BL         = 8;
    localparam int BL_MRR     = 4;

    // Least times round up to whole system clocks
    localparam logic [7:0] C_TRCD   = 8'((T_RCD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] C_TRAS   = 8'((T_RAS_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] C_TRPPB  = 8'((T_RPPB_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] C_TRPAB  = 8'((T_RPAB_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] C_TRC    = 8'((T_RC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] C_TRRD   = 8'((T_RRD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] C_TFAW   = 8'((T_FAW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] C_TRFCAB = 8'((T_RFCAB_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] C_TRFCPB = 8'((T_RFCPB_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] C_TXP    = 8'((T_XP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] C_TWR    = 8'((T_WR_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] C_TMRR   = 8'(T_MRR_CK * CK_DIV);
    localparam logic [7:0] C_TMRW   = 8'(T_MRW_CK * CK_DIV);

    // Data path positions in system clocks
    localparam logic [7:0] C_RD_SPAN = 8'((RL_CK + BL / 2 + 2) * CK_DIV);
    localparam logic [7:0] C_RD_OPEN = 8'((BL / 2 + 3) * CK_DIV);
    localparam logic [3:0] C_BEATS   = 4'(BL);
    localparam logic [3:0] C_BEATS_M = 4'(BL_MRR);
    localparam logic [7:0] C_WR_D0   = 8'(1 + WL_CK * CK_DIV);
    localparam logic [7:0] C_WR_PRE  = 8'(1 + (WL_CK - 1) * CK_DIV);
    localparam logic [7:0] C_WR_DEND = 8'(1 + WL_CK * CK_DIV + BL * 2);
    localparam logic [7:0] C_WR_POST = 8'(3 + WL_CK * CK_DIV + BL * 2);
    localparam logic [7:0] C_WR_END  = C_WR_POST + C_TWR;
    localparam logic [7:0] C_AP_RD   = 8'(BL / 2 * CK_DIV);
    localparam logic [7:0] C_AP_WR   = C_WR_END;

endpackage

// File: rtl/lpc_bank.sv
// Per-bank state and timing tracker
`timescale 1ns/1ps
module lpc_bank (
    input  wire logic i_clock,
    input  wire logic i_sys_rst,
    input  wire logic i_act,
    input  wire logic i_pre,
    input  wire logic i_pre_ab,
    input  wire logic i_ref,
    input  wire logic i_ap_rd,
    input  wire logic i_ap_wr,
    output logic      o_open,
    output logic      o_idle,
    output logic      o_act_ok,
    output logic      o_col_ok,
    output logic      o_pre_ok
);
    import lpc_pkg::*;

    logic       open_r, open_nxt, ap_r, ap_nxt;
    logic [7:0] rcd_r, rcd_nxt, ras_r, ras_nxt, rc_r, rc_nxt;
    logic [7:0] rp_r, rp_nxt, apc_r, apc_nxt;

    always_comb begin
        open_nxt = open_r;
        ap_nxt   = ap_r;
        rcd_nxt  = (rcd_r != 8'h00) ? rcd_r - 8'h01 : rcd_r;
        ras_nxt  = (ras_r != 8'h00) ? ras_r - 8'h01 : ras_r;
        rc_nxt   = (rc_r != 8'h00) ? rc_r - 8'h01 : rc_r;
        rp_nxt   = (rp_r != 8'h00) ? rp_r - 8'h01 : rp_r;
        apc_nxt  = (apc_r != 8'h00) ? apc_r - 8'h01 : apc_r;
        if (i_act) begin
            open_nxt = 1'b1;
            rcd_nxt  = C_TRCD;
            ras_nxt  = C_TRAS;
            rc_nxt   = C_TRC;
        end
        if (i_pre) begin
            open_nxt = 1'b0;
            rp_nxt   = i_pre_ab ? C_TRPAB : C_TRPPB;
        end
        if (i_ref) begin
            rp_nxt = C_TRFCPB;
        end
        // auto precharge closes only this bank
        if (i_ap_rd || i_ap_wr) begin
            ap_nxt  = 1'b1;
            apc_nxt = i_ap_wr ? C_AP_WR : C_AP_RD;
        end else if (ap_r && apc_r == 8'h00 && ras_r == 8'h00) begin
            ap_nxt   = 1'b0;
            open_nxt = 1'b0;
            rp_nxt   = C_TRPPB;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            open_r <= 1'b0;
            ap_r   <= 1'b0;
            rcd_r  <= 8'h00;
            ras_r  <= 8'h00;
            rc_r   <= 8'h00;
            rp_r   <= 8'h00;
            apc_r  <= 8'h00;
        end else begin
            open_r <= open_nxt;
            ap_r   <= ap_nxt;
            rcd_r  <= rcd_nxt;
            ras_r  <= ras_nxt;
            rc_r   <= rc_nxt;
            rp_r   <= rp_nxt;
            apc_r  <= apc_nxt;
        end
    end

    // idle only once precharge time is over
    assign o_idle   = !open_r && rp_r == 8'h00 && !ap_r;
    assign o_open   = open_r || ap_r;
    assign o_act_ok = o_idle && rc_r == 8'h00;
    assign o_col_ok = open_r && rcd_r == 8'h00 && !ap_r;
    assign o_pre_ok = (!open_r || ras_r == 8'h00) && !ap_r;
endmodule

// File: rtl/lpc_faw.sv
// Rolling four-activate window tracker
`timescale 1ns/1ps
module lpc_faw (
    input  wire logic i_clock,
    input  wire logic i_sys_rst,
    input  wire logic i_act,
    output logic      o_ok
);
    import lpc_pkg::*;

    logic [3:0][7:0] slot_r;
    logic [3:0][7:0] slot_nxt;
    logic [3:0]      free;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_slot
            assign free[g] = slot_r[g] == 8'h00;
        end
    endgenerate

    // each activate holds a slot for the window
    always_comb begin
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < 4; k++) begin
            slot_nxt[k] = free[k] ? slot_r[k] : slot_r[k] - 8'h01;
            if (i_act && free[k] && !hit) begin
                slot_nxt[k] = C_TFAW;
                hit         = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            slot_r <= '0;
        end else begin
            slot_r <= slot_nxt;
        end
    end

    assign o_ok = |free;
endmodule

// File: rtl/lpc_host_ctrl.sv
// Host controller driving a low-power DDR SDRAM over its pins
//
// Notes on behaviour
// - Commands only with clock enable high two edges and exit time met.
// - Illegal or unknown commands are refused with an error pulse.
// - All-bank refresh and register writes only when every bank is idle.
// - After register read or write, only no-operations until time passes.
// - Bank-to-bank activate spacing kept between activates.
// - No write before read burst ends, no read before write ends.
// - Column command waits activate-to-column delay.
// - Precharge before re-activate; row cycle time between activates.
// - At most four activations or bank refreshes per window.
// - Window converted to clocks by rounding up.
// - Precharge-all uses the longer all-bank precharge time.
// - Bursts run whole; column from rising and falling halves.
`timescale 1ns/1ps
module lpc_host_ctrl (
    input  wire logic        i_clock,
    input  wire logic        i_sys_rst,
    input  wire logic        i_req_valid,
    input  wire logic [3:0]  i_req_cmd,
    input  wire logic [2:0]  i_req_bank,
    input  wire logic [14:0] i_req_row,
    input  wire logic [9:0]  i_req_col,
    input  wire logic        i_req_ap,
    input  wire logic [7:0]  i_req_ma,
    input  wire logic [7:0]  i_req_op,
    input  wire logic        i_pd_req,
    input  wire logic [31:0] i_wr_data,
    input  wire logic [3:0]  i_wr_mask,
    output logic             o_req_done,
    output logic             o_req_err,
    output logic             o_wr_pull,
    output logic [31:0]      o_rd_data,
    output logic             o_rd_valid,
    output logic             o_ck,
    output logic             o_cke,
    output logic             o_cs_n,
    output logic [9:0]       o_ca,
    input  wire logic [31:0] i_dq,
    output logic [31:0]      o_dq,
    output logic             o_dq_oe_n,
    input  wire logic [3:0]  i_dqs,
    output logic [3:0]       o_dqs,
    output logic             o_dqs_oe_n,
    output logic [3:0]       o_dm
);
    import lpc_pkg::*;

    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_WAIT = 3'b010,
        ST_PD   = 3'b100
    } lpc_state_e;

    lpc_state_e  st_r, st_nxt;
    logic [1:0]  ph_r, ph_nxt, hist_r, hist_nxt;
    logic [7:0]  nop_r, nop_nxt, rrd_r, rrd_nxt, xp_r, xp_nxt;
    logic        ck_nxt, cke_nxt, cs_n_nxt;
    logic [9:0]  ca_nxt, fall_r, fall_nxt, rise, fall;
    logic        done_nxt, err_nxt;
    logic        dec, ok, bad, acc, faw_ok;
    logic [7:0]  bank_sel;
    logic [7:0]  b_open, b_idle, b_act, b_col, b_pre;

    // Command decode and legality check
    assign dec      = ph_r == PH_DEC && st_r == ST_RUN && i_req_valid;
    assign bank_sel = 8'h01 << i_req_bank;

    logic       rd_busy, wr_busy, burst;
    logic       cke_ok;
    // two sampled-high edges and exit time
    assign cke_ok = hist_r == 2'b11 && xp_r == 8'h00;
    assign burst  = rd_busy || wr_busy;

    always_comb begin
        ok  = 1'b0;
        bad = 1'b0;
        case (i_req_cmd)
            CMD_ACT: begin
                bad = b_open[i_req_bank];
                ok  = b_act[i_req_bank] && rrd_r == 8'h00 && faw_ok;
            end
            CMD_RD: begin
                bad = !b_open[i_req_bank];
                ok  = b_col[i_req_bank] && !burst;
            end
            CMD_WR: begin
                bad = !b_open[i_req_bank];
                ok  = b_col[i_req_bank] && !burst;
            end
            CMD_PRE:   ok = b_pre[i_req_bank] && !burst;
            CMD_PREA:  ok = &b_pre && !burst;
            // all banks idle for refresh and writes
            CMD_REFAB: ok = &b_idle && !burst;
            CMD_MRW:   ok = &b_idle && !burst;
            CMD_REFPB: begin
                bad = b_open[i_req_bank];
                ok  = b_act[i_req_bank] && rrd_r == 8'h00 && faw_ok;
            end
            // register read even while banks change state
            CMD_MRR:   ok = !burst;
            default:   bad = 1'b1;
        endcase
    end

    assign acc = dec && cke_ok && ok && !bad;

    // Command bus encoding
    always_comb begin
        rise = 10'h000;
        fall = 10'h000;
        case (i_req_cmd)
            CMD_ACT: begin
                rise = {i_req_bank, i_req_row[12:8], OPC_ACT};
                fall = {i_req_row[7:0], i_req_row[14:13]};
            end
            CMD_RD: begin
                rise = {i_req_bank, i_req_col[2:1], 2'b00, OPC_RD};
                fall = {2'b00, i_req_col[9:3], i_req_ap};
            end
            CMD_WR: begin
                rise = {i_req_bank, i_req_col[2:1], 2'b00, OPC_WR};
                fall = {2'b00, i_req_col[9:3], i_req_ap};
            end
            CMD_PRE:   rise = {i_req_bank, 3'b000, OPC_PRE};
            CMD_PREA:  rise = {i_req_bank, 3'b001, OPC_PRE};
            CMD_REFAB: rise = {i_req_bank, 3'b001, OPC_REF};
            CMD_REFPB: rise = {i_req_bank, 3'b000, OPC_REF};
            CMD_MRW: begin
                rise = {i_req_ma[5:0], OPC_MRW};
                fall = {i_req_op, i_req_ma[7:6]};
            end
            CMD_MRR: begin
                rise = {i_req_ma[5:0], OPC_MRR};
                fall = {8'h00, i_req_ma[7:6]};
            end
            default: begin
                rise = 10'h000;
                fall = 10'h000;
            end
        endcase
    end

    // Bank trackers
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_bank
            lpc_bank u_bank (
                .i_clock   (i_clock),
                .i_sys_rst (i_sys_rst),
                .i_act     (acc && i_req_cmd == CMD_ACT && bank_sel[g]),
                .i_pre     (acc && (i_req_cmd == CMD_PREA
                            || (i_req_cmd == CMD_PRE && bank_sel[g]))),
                .i_pre_ab  (i_req_cmd == CMD_PREA),
                .i_ref     (acc && i_req_cmd == CMD_REFPB && bank_sel[g]),
                .i_ap_rd   (acc && i_req_cmd == CMD_RD && i_req_ap
                            && bank_sel[g]),
                .i_ap_wr   (acc && i_req_cmd == CMD_WR && i_req_ap
                            && bank_sel[g]),
                .o_open    (b_open[g]),
                .o_idle    (b_idle[g]),
                .o_act_ok  (b_act[g]),
                .o_col_ok  (b_col[g]),
                .o_pre_ok  (b_pre[g])
            );
        end
    endgenerate

    lpc_faw u_faw (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_act     (acc && (i_req_cmd == CMD_ACT
                    || i_req_cmd == CMD_REFPB)),
        .o_ok      (faw_ok)
    );

    // Clock divider, command sequencing, power-down
    always_comb begin
        ph_nxt   = ph_r + 2'h1;
        ck_nxt   = !ph_nxt[1];
        st_nxt   = st_r;
        cke_nxt  = o_cke;
        hist_nxt = hist_r;
        nop_nxt  = (nop_r != 8'h00) ? nop_r - 8'h01 : nop_r;
        rrd_nxt  = (rrd_r != 8'h00) ? rrd_r - 8'h01 : rrd_r;
        xp_nxt   = (xp_r != 8'h00) ? xp_r - 8'h01 : xp_r;
        cs_n_nxt = o_cs_n;
        ca_nxt   = o_ca;
        fall_nxt = fall_r;
        done_nxt = acc;
        err_nxt  = dec && bad;
        if (ph_r == PH_LAST) begin
            hist_nxt = {hist_r[0], o_cke};
        end
        if (ph_r == PH_DEC) begin
            cs_n_nxt = !acc;
            if (acc) begin
                ca_nxt   = rise;
                fall_nxt = fall;
            end
        end else if (ph_r == PH_FALL && !o_cs_n) begin
            ca_nxt = fall_r;
        end
        if (acc && (i_req_cmd == CMD_ACT || i_req_cmd == CMD_REFPB)) begin
            rrd_nxt = C_TRRD;
        end
        case (st_r)
            ST_RUN: begin
                if (acc) begin
                    case (i_req_cmd)
                        CMD_MRR: nop_nxt = C_TMRR;
                        CMD_MRW: nop_nxt = C_TMRW;
                        CMD_REFAB: nop_nxt = C_TRFCAB;
                        CMD_PREA: nop_nxt = C_TRPAB;
                        default: nop_nxt = 8'h00;
                    endcase
                    if (i_req_cmd == CMD_MRR || i_req_cmd == CMD_MRW
                        || i_req_cmd == CMD_REFAB
                        || i_req_cmd == CMD_PREA) begin
                        st_nxt = ST_WAIT;
                    end
                end else if (ph_r == PH_DEC && i_pd_req && !burst
                             && !i_req_valid) begin
                    cke_nxt = 1'b0;
                    st_nxt  = ST_PD;
                end
            end
            ST_WAIT: begin
                if (nop_r == 8'h00) begin
                    st_nxt = ST_RUN;
                end
            end
            ST_PD: begin
                if (ph_r == PH_DEC && !i_pd_req) begin
                    cke_nxt = 1'b1;
                    xp_nxt  = C_TXP;
                    st_nxt  = ST_RUN;
                end
            end
            default: st_nxt = ST_RUN;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            st_r       <= ST_RUN;
            // Phase 3 so the first memory clock high is full width
            ph_r       <= PH_LAST;
            hist_r     <= 2'b00;
            nop_r      <= 8'h00;
            rrd_r      <= 8'h00;
            xp_r       <= 8'h00;
            fall_r     <= 10'h000;
            o_ck       <= 1'b0;
            o_cke      <= 1'b1;
            o_cs_n     <= 1'b1;
            o_ca       <= 10'h000;
            o_req_done <= 1'b0;
            o_req_err  <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            ph_r       <= ph_nxt;
            hist_r     <= hist_nxt;
            nop_r      <= nop_nxt;
            rrd_r      <= rrd_nxt;
            xp_r       <= xp_nxt;
            fall_r     <= fall_nxt;
            o_ck       <= ck_nxt;
            o_cke      <= cke_nxt;
            o_cs_n     <= cs_n_nxt;
            o_ca       <= ca_nxt;
            o_req_done <= done_nxt;
            o_req_err  <= err_nxt;
        end
    end

    // Read capture; strobe and data share the same two-stage delay
    logic [31:0] dq_s1, dq_s2;
    logic        dqs_s1, dqs_s2, dqs_s3;
    logic [7:0]  rdc_r, rdc_nxt;
    logic [3:0]  beats_r, beats_nxt;
    logic [31:0] rdd_nxt;
    logic        rdv_nxt;

    assign rd_busy = rdc_r != 8'h00;

    // reading lasts until all beats arrive or C_RD_SPAN runs out
    always_comb begin
        rdc_nxt   = rd_busy ? rdc_r - 8'h01 : rdc_r;
        beats_nxt = beats_r;
        rdd_nxt   = o_rd_data;
        rdv_nxt   = 1'b0;
        if (acc && (i_req_cmd == CMD_RD || i_req_cmd == CMD_MRR)) begin
            rdc_nxt   = C_RD_SPAN;
            beats_nxt = (i_req_cmd == CMD_MRR) ? C_BEATS_M : C_BEATS;
        end else if (rd_busy && rdc_r <= C_RD_OPEN && beats_r != 4'h0
                     && dqs_s2 != dqs_s3) begin
            rdd_nxt   = dq_s2;
            rdv_nxt   = 1'b1;
            beats_nxt = beats_r - 4'h1;
        end
        if (rd_busy && beats_nxt == 4'h0 && !acc) begin
            rdc_nxt = 8'h00;
        end
    end

    always_ff @(posedge i_clock) begin
        dq_s1  <= i_dq;
        dq_s2  <= dq_s1;
        dqs_s1 <= i_dqs[0];
        dqs_s2 <= dqs_s1;
        dqs_s3 <= dqs_s2;
        if (i_sys_rst) begin
            rdc_r      <= 8'h00;
            beats_r    <= 4'h0;
            o_rd_data  <= 32'h0000_0000;
            o_rd_valid <= 1'b0;
        end else begin
            rdc_r      <= rdc_nxt;
            beats_r    <= beats_nxt;
            o_rd_data  <= rdd_nxt;
            o_rd_valid <= rdv_nxt;
        end
    end

    // Write burst: preamble, center-aligned strobe, postamble
    logic [7:0]  wp_r, wp_nxt;
    logic        wact_r, wact_nxt, pull_nxt, dqs_lvl;
    logic [31:0] wdq_nxt;
    logic [3:0]  wdm_nxt;

    assign wr_busy = wact_r;

    always_comb begin
        wact_nxt = wact_r;
        wp_nxt   = wact_r ? wp_r + 8'h01 : 8'h00;
        pull_nxt = 1'b0;
        dqs_lvl  = 1'b0;
        if (acc && i_req_cmd == CMD_WR) begin
            wact_nxt = 1'b1;
            wp_nxt   = 8'h00;
        end else if (wact_r && wp_r == C_WR_END) begin
            wact_nxt = 1'b0;
        end
        if (wact_r && wp_r + 8'h02 >= C_WR_D0 && wp_r + 8'h02 < C_WR_DEND
            && !wp_r[0]) begin
            pull_nxt = 1'b1;
        end
        if (wact_r && wp_nxt >= C_WR_D0 && wp_nxt < C_WR_DEND) begin
            dqs_lvl = wp_nxt[0] ^ (wp_nxt[1] ^ C_WR_D0[1]) ^ C_WR_D0[0];
        end
        // mask travels with its data beat
        wdq_nxt = o_wr_pull ? i_wr_data : o_dq;
        wdm_nxt = o_wr_pull ? i_wr_mask : o_dm;
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            wact_r     <= 1'b0;
            wp_r       <= 8'h00;
            o_wr_pull  <= 1'b0;
            o_dq       <= 32'h0000_0000;
            o_dm       <= 4'h0;
            o_dqs      <= 4'h0;
            o_dq_oe_n  <= 1'b1;
            o_dqs_oe_n <= 1'b1;
        end else begin
            wact_r     <= wact_nxt;
            wp_r       <= wp_nxt;
            o_wr_pull  <= pull_nxt;
            o_dq       <= wdq_nxt;
            o_dm       <= wdm_nxt;
            o_dqs      <= {4{dqs_lvl}};
            // Beats land a cycle after their pull; cover the last one
            o_dq_oe_n  <= !(wact_nxt && wp_nxt > C_WR_D0
                           && wp_nxt <= C_WR_DEND);
            o_dqs_oe_n <= !(wact_nxt && wp_nxt >= C_WR_PRE
                           && wp_nxt < C_WR_POST);
        end
    end
endmodule

// File: tb/lpc_dev_model.sv
// Device model: command decode, read bursts, masked writes
`timescale 1ns/1ps
module lpc_dev_model (
    input  wire logic        i_ck,
    input  wire logic        i_cs_n,
    input  wire logic [9:0]  i_ca,
    input  wire logic [31:0] i_dq,
    input  wire logic [3:0]  i_dqs,
    input  wire logic [3:0]  i_dm,
    input  wire logic        i_dqs_oe_n,
    output logic [31:0]      o_dq,
    output logic [3:0]       o_dqs,
    output logic [2:0]       o_bank
);
    import lpc_pkg::*;
    logic [31:0] mem [8];
    int          wn = 8;
    initial begin
        o_dq = '0;
        o_dqs = '0;
        o_bank = '0;
        foreach (mem[k]) mem[k] = '1;
    end
    always @(posedge i_ck) if (!i_cs_n) begin
        if (i_ca[1:0] == 2'h2) o_bank <= i_ca[9:7];
        if (i_ca[2:0] == 3'h1) wn <= 0;
        if (i_ca[2:0] == 3'h5) fork rd_burst(); join_none
    end
    task automatic rd_burst;
        repeat (RL_CK) @(posedge i_ck);
        for (int k = 0; k < 8; k++) begin
            o_dq = mem[k];
            #10 o_dqs = ~o_dqs;
            #40;
        end
        // Released bus must not keep the last beat
        o_dq = ~o_dq;
    endtask
    // byte kept only when its mask is low
    always @(i_dqs[0]) if (!i_dqs_oe_n && wn < 8) begin
        for (int b = 0; b < 4; b++)
            if (!i_dm[b]) mem[wn][8*b+:8] = i_dq[8*b+:8];
        wn = wn + 1;
    end
endmodule

// File: tb/lpc_properties.sv
// Port checks of the SDRAM host controller
`timescale 1ns/1ps
module lpc_properties (
    input wire logic        i_clock,
    input wire logic        i_sys_rst,
    input wire logic [31:0] i_wr_data,
    input wire logic [3:0]  i_wr_mask,
    input wire logic        o_req_done,
    input wire logic        o_req_err,
    input wire logic        o_wr_pull,
    input wire logic        o_rd_valid,
    input wire logic        o_ck,
    input wire logic        o_cke,
    input wire logic        o_cs_n,
    input wire logic [31:0] o_dq,
    input wire logic        o_dq_oe_n,
    input wire logic        o_dqs_oe_n,
    input wire logic [3:0]  o_dm
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    sequence s_cmd; !o_cs_n[*4]; endsequence
    sequence s_ck; o_ck[*2] ##1 !o_ck[*2] ##1 o_ck; endsequence
    a_cs_width: assert property ($fell(o_cs_n) |-> s_cmd)
        else $error("chip select low too briefly");
    a_ck_period: assert property ($rose(o_ck) |-> s_ck)
        else $error("memory clock period wrong");
    a_done_cmd: assert property (o_req_done |-> !o_cs_n)
        else $error("accepted without command");
    a_err_quiet: assert property (o_req_err |-> o_cs_n)
        else $error("refused command reached pins");
    a_one_answer: assert property (o_req_done |-> !o_req_err)
        else $error("done and error together");
    a_cke_cmd: assert property (!o_cs_n |-> o_cke && $past(o_cke))
        else $error("command without clock enable");
    a_mask_beat: assert property (o_wr_pull |=>
        o_dm == $past(i_wr_mask) && o_dq == $past(i_wr_data))
        else $error("mask not with its data");
    a_wr_drive: assert property (o_wr_pull |=>
        !o_dq_oe_n && !o_dqs_oe_n)
        else $error("write beat not driven");
    a_rd_quiet: assert property (o_rd_valid |-> o_dq_oe_n)
        else $error("driving data during read");
endmodule
bind lpc_host_ctrl lpc_properties u_chk (.i_clock, .i_sys_rst, .i_wr_data,
    .i_wr_mask, .o_req_done, .o_req_err, .o_wr_pull, .o_rd_valid, .o_ck,
    .o_cke, .o_cs_n, .o_dq, .o_dq_oe_n, .o_dqs_oe_n, .o_dm);

// File: tb/lpc_host_ctrl_bench.sv
// Self-checking bench for the SDRAM host controller
`timescale 1ns/1ps
module lpc_host_ctrl_bench;
    import lpc_pkg::*;
    logic i_clock = 0, i_sys_rst = 1, i_req_valid = 0, i_req_ap = 0;
    logic i_pd_req = 0, o_req_done, o_req_err, o_wr_pull, o_rd_valid;
    logic o_ck, o_cke, o_cs_n, o_dq_oe_n, o_dqs_oe_n;
    logic [3:0]  i_req_cmd = '0, i_wr_mask = '0, o_dqs, o_dm, m_dqs;
    logic [2:0]  i_req_bank = '0, m_bank;
    logic [14:0] i_req_row = '0;
    logic [9:0]  i_req_col = 10'h008, o_ca;
    logic [7:0]  i_req_ma = 8'h04, i_req_op = 8'h00;
    logic [31:0] i_wr_data = '0, o_rd_data, o_dq, m_dq, rq [$];
    wire  [31:0] i_dq = o_dq_oe_n ? m_dq : o_dq;
    wire  [3:0]  i_dqs = o_dqs_oe_n ? m_dqs : o_dqs;
    int          fail_count = 0, n_compared = 0, npull = 0;
    lpc_host_ctrl DUT (.*);
    lpc_dev_model u_dev (.i_ck(o_ck), .i_cs_n(o_cs_n), .i_ca(o_ca),
        .i_dq(i_dq), .i_dqs(i_dqs), .i_dm(o_dm), .i_dqs_oe_n(o_dqs_oe_n),
        .o_dq(m_dq), .o_dqs(m_dqs), .o_bank(m_bank));
    initial forever #12.5 i_clock = ~i_clock;
    always @(posedge i_clock) if (o_wr_pull) npull <= npull + 1;
    always @(posedge i_clock) if (o_rd_valid) rq.push_back(o_rd_data);
    // Beat 1 masks byte 0 so the old content must survive
    always @(negedge i_clock) begin
        i_wr_data <= 32'(32'h11111111 * (npull + 1));
        i_wr_mask <= (npull == 1) ? 4'h1 : 4'h0;
    end
    task automatic chk(input string s, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic req(input logic [3:0] c, input logic [2:0] b, input e);
        int n = 0;
        @(negedge i_clock);
        i_req_cmd = c;
        i_req_bank = b;
        i_req_row = {12'h0A5, b};
        i_req_valid = 1;
        while (o_req_done !== 1 && o_req_err !== 1 && n < 600) begin
            @(posedge i_clock);
            #1 n++;
        end
        chk("answer", {30'h0, e, !e}, {30'h0, o_req_err, o_req_done});
        @(negedge i_clock);
        i_req_valid = 0;
    endtask
    task automatic t_reset;
        chk("cs_n", 1, o_cs_n);
        chk("cke", 1, o_cke);
        $display("test reset ended");
    endtask
    task automatic t_wr_rd;
        int n = 0;
        req(CMD_ACT, 3'h2, 0);
        req(CMD_WR, 3'h2, 0);
        chk("bank", 3'h2, m_bank);
        rq.delete();
        req(CMD_RD, 3'h2, 0);
        while (rq.size() < 8 && n < 200) begin
            @(posedge i_clock);
            n++;
        end
        for (int k = 0; k < 8; k++)
            chk("beat", 32'(32'h11111111*(k+1)) | (k==1 ? 32'hFF : 0),
                rq[k]);
        $display("test write read ended");
    endtask
    task automatic t_flow;
        req(CMD_ACT, 3'h2, 1);
        req(CMD_MRR, 3'h2, 0);
        req(CMD_PRE, 3'h2, 0);
        req(CMD_REFPB, 3'h1, 0);
        for (int b = 0; b < 5; b++) req(CMD_ACT, 3'(b), 0);
        req(CMD_PREA, 3'h0, 0);
        req(CMD_MRW, 3'h0, 0);
        req(CMD_REFAB, 3'h0, 0);
        $display("test command flow ended");
    endtask
    task automatic t_err;
        req(CMD_RD, 3'h3, 1);
        req(4'hF, 3'h0, 1);
        $display("test refusals ended");
    endtask
    task automatic t_pd;
        i_pd_req = 1;
        repeat (8) @(negedge i_clock);
        chk("cke", 0, o_cke);
        i_pd_req = 0;
        req(CMD_ACT, 3'h5, 0);
        i_req_ap = 1;
        req(CMD_RD, 3'h5, 0);
        i_req_ap = 0;
        req(CMD_ACT, 3'h6, 0);
        $display("test power-down ended");
    endtask
    task automatic final_report;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clock);
        fail_count++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge i_clock);
        @(negedge i_clock);
        t_reset();
        i_sys_rst = 0;
        t_wr_rd();
        t_flow();
        t_err();
        t_pd();
        final_report();
    end
endmodule
